/* phy_ready_timer_led_stretch.sv */
// start-up timer, ready flag, indicator pins and axi4-lite registers
//
// The AXI4-Lite slave port and the register addresses were decided locally.
`timescale 1ns/1ps
module phy_ready_timer_led_stretch #(
  parameter int unsigned STARTUP_CYCLES = phy_timer_pkg::STARTUP_CYCLES,
  parameter int unsigned STR_NORMAL     = phy_timer_pkg::STR_NORMAL_CYC,
  parameter int unsigned STR_MEDIUM     = phy_timer_pkg::STR_MEDIUM_CYC,
  parameter int unsigned STR_LONG       = phy_timer_pkg::STR_LONG_CYC,
  parameter int unsigned CNT_W          = phy_timer_pkg::STR_CNT_W
) (
  input  wire logic                     clk_in,
  input  wire logic                     rst_b_in,
  input  wire logic                     ce_in,
  input  wire phy_timer_pkg::axil_m2s_t axil_in,
  output phy_timer_pkg::axil_s2m_t      axil_out,
  input  wire phy_timer_pkg::net_events_t events_in,
  input  wire logic                     indicator_fuse_bit_in,
  input  wire logic [1:0]               port_a_pins_in,
  output logic                          port_a_bit0_out,
  output logic                          port_a_bit0_oe_out,
  output logic                          port_a_bit1_out,
  output logic                          port_a_bit1_oe_out,
  output logic                          net_unit_enable_out,
  output logic                          phy_ready_flag_out
);

  localparam int unsigned UP_W = $clog2(STARTUP_CYCLES + 1);
  localparam logic [UP_W-1:0] UP_LAST = UP_W'(STARTUP_CYCLES - 1);

  // ****************************************************************
  // parameter checks
  // ****************************************************************
  if (STARTUP_CYCLES < 1 || STR_NORMAL < 1 || STR_MEDIUM < 1 || STR_LONG < 1) begin : g_bad_len
    $error("timing counts must be at least one cycle");
  end
  if (CNT_W > 31 || STR_LONG >= (32'h1 << CNT_W) || STR_MEDIUM >= (32'h1 << CNT_W)
      || STR_NORMAL >= (32'h1 << CNT_W)) begin : g_bad_w
    $error("stretch counter too narrow");
  end

  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0]  strb);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic pick_event(input logic [2:0] mode,
                                      input phy_timer_pkg::net_events_t ev);
    logic r;
    case (mode)
      phy_timer_pkg::MODE_TX:    r = ev.tx_act;
      phy_timer_pkg::MODE_RX:    r = ev.rx_act;
      phy_timer_pkg::MODE_COL:   r = ev.collision;
      phy_timer_pkg::MODE_TXRX,
      phy_timer_pkg::MODE_BLINK: r = ev.tx_act | ev.rx_act;
      default:                   r = 1'b0;
    endcase
    return r;
  endfunction

  // ****************************************************************
  // state
  // ****************************************************************
  logic                           awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
  logic [1:0]                     bresp_q, rresp_q;
  logic [31:0]                    rdata_q;
  logic                           aw_got_q, w_got_q;
  logic [phy_timer_pkg::ADDR_W-1:0] aw_addr_q;
  logic [31:0]                    w_data_q;
  logic [3:0]                     w_strb_q;
  logic                           en_q;
  logic [phy_timer_pkg::LEDCFG_W-1:0] ledcfg_q;
  logic [1:0]                     dir_q, port_data_q, pin_q, oe_q;
  logic                           fuse_q;
  phy_timer_pkg::up_state_t       state_q, state_d;
  logic [UP_W-1:0]                cnt_q, cnt_d;

  // ****************************************************************
  // axi4-lite write path
  // ****************************************************************
  wire        aw_take  = axil_in.awvalid & awready_q;
  wire        w_take   = axil_in.wvalid & wready_q;
  wire        aw_have  = aw_got_q | aw_take;
  wire        w_have   = w_got_q | w_take;
  wire        wr_fire  = aw_have & w_have & ~bvalid_q;
  wire [7:0]  wr_addr  = aw_got_q ? aw_addr_q : axil_in.awaddr;
  wire [31:0] wr_data  = w_got_q ? w_data_q : axil_in.wdata;
  wire [3:0]  wr_strb  = w_got_q ? w_strb_q : axil_in.wstrb;
  wire        aw_got_d = aw_have & ~wr_fire;
  wire        w_got_d  = w_have & ~wr_fire;
  wire        bvalid_d = wr_fire | (bvalid_q & ~axil_in.bready);

  wire wr_ctrl = wr_fire & (wr_addr == phy_timer_pkg::CTRL_OFS);
  wire wr_led  = wr_fire & (wr_addr == phy_timer_pkg::LEDCFG_OFS);
  wire wr_dir  = wr_fire & (wr_addr == phy_timer_pkg::DIR_OFS);
  wire wr_port = wr_fire & (wr_addr == phy_timer_pkg::PORT_OFS);
  wire wr_ok   = wr_ctrl | wr_led | wr_dir | wr_port
               | (wr_addr == phy_timer_pkg::STATUS_OFS);

  // status is read-only; writes there are accepted and dropped
  wire [31:0] ctrl_word = 32'(en_q) << phy_timer_pkg::ENABLE_BIT;
  wire [31:0] ctrl_new  = merge(ctrl_word, wr_data, wr_strb);
  wire [31:0] led_new   = merge(32'(ledcfg_q), wr_data, wr_strb);
  wire [31:0] dir_new   = merge(32'(dir_q), wr_data, wr_strb);
  wire [31:0] port_new  = merge(32'(port_data_q), wr_data, wr_strb);
  wire        en_d      = wr_ctrl ? ctrl_new[phy_timer_pkg::ENABLE_BIT] : en_q;

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      awready_q <= 1'b0;
      wready_q  <= 1'b0;
      bvalid_q  <= 1'b0;
      bresp_q   <= phy_timer_pkg::RESP_OKAY;
      aw_got_q  <= 1'b0;
      w_got_q   <= 1'b0;
      aw_addr_q <= '0;
      w_data_q  <= '0;
      w_strb_q  <= '0;
    end else if (ce_in) begin
      awready_q <= ~aw_got_d & ~bvalid_d;
      wready_q  <= ~w_got_d & ~bvalid_d;
      bvalid_q  <= bvalid_d;
      aw_got_q  <= aw_got_d;
      w_got_q   <= w_got_d;
      if (aw_take) aw_addr_q <= axil_in.awaddr;
      if (w_take) begin
        w_data_q <= axil_in.wdata;
        w_strb_q <= axil_in.wstrb;
      end
      if (wr_fire) bresp_q <= wr_ok ? phy_timer_pkg::RESP_OKAY : phy_timer_pkg::RESP_SLVERR;
    end
  end

  // ****************************************************************
  // axi4-lite read path
  // ****************************************************************
  wire        ar_take  = axil_in.arvalid & arready_q;
  wire        rvalid_d = ar_take | (rvalid_q & ~axil_in.rready);
  wire [7:0]  ra       = axil_in.araddr;
  wire        rd_ok    = (ra == phy_timer_pkg::CTRL_OFS) | (ra == phy_timer_pkg::STATUS_OFS)
                       | (ra == phy_timer_pkg::LEDCFG_OFS) | (ra == phy_timer_pkg::DIR_OFS)
                       | (ra == phy_timer_pkg::PORT_OFS);
  wire [31:0] rd_val   =
      (ra == phy_timer_pkg::CTRL_OFS)   ? ctrl_word :
      (ra == phy_timer_pkg::STATUS_OFS) ? 32'(state_q[2]) << phy_timer_pkg::READY_BIT :
      (ra == phy_timer_pkg::LEDCFG_OFS) ? 32'(ledcfg_q) :
      (ra == phy_timer_pkg::DIR_OFS)    ? 32'(dir_q) :
      (ra == phy_timer_pkg::PORT_OFS)   ? 32'(port_a_pins_in) : 32'h0;

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b0;
      rdata_q   <= '0;
      rresp_q   <= phy_timer_pkg::RESP_OKAY;
    end else if (ce_in) begin
      arready_q <= ~rvalid_d;
      rvalid_q  <= rvalid_d;
      if (ar_take) begin
        rdata_q <= rd_val;
        rresp_q <= rd_ok ? phy_timer_pkg::RESP_OKAY : phy_timer_pkg::RESP_SLVERR;
      end
    end
  end

  assign axil_out = '{awready: awready_q, wready: wready_q, bvalid: bvalid_q,
                      bresp: bresp_q, arready: arready_q, rvalid: rvalid_q,
                      rdata: rdata_q, rresp: rresp_q};

  // ****************************************************************
  // start-up timer
  // ****************************************************************
  // clear acts at the same edge as the enable write, so ready never outlives it
  always_comb begin
    state_d = state_q;
    cnt_d   = '0;
    case (state_q)
      phy_timer_pkg::ST_OFF: begin
        if (en_d) state_d = phy_timer_pkg::ST_WARM;
      end
      phy_timer_pkg::ST_WARM: begin
        if (!en_d) begin
          state_d = phy_timer_pkg::ST_OFF;
        end else if (cnt_q == UP_LAST) begin
          state_d = phy_timer_pkg::ST_READY;
        end else begin
          cnt_d = cnt_q + 1'b1;
        end
      end
      phy_timer_pkg::ST_READY: begin
        if (!en_d) state_d = phy_timer_pkg::ST_OFF;
      end
      default: state_d = phy_timer_pkg::ST_OFF;
    endcase
  end

  // counter from zero on each enable
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state_q <= phy_timer_pkg::ST_OFF;
      cnt_q   <= '0;
      en_q    <= 1'b0;
    end else if (ce_in) begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      en_q    <= en_d;
    end
  end

  assign net_unit_enable_out = en_q;
  assign phy_ready_flag_out  = state_q[2];

  // ****************************************************************
  // indicators
  // ****************************************************************
  wire [1:0]       str_sel = ledcfg_q[phy_timer_pkg::STR_SEL_LSB +: 2];
  wire             str_en  = ledcfg_q[phy_timer_pkg::STR_EN_BIT];
  wire [CNT_W-1:0] str_len = (str_sel == phy_timer_pkg::SEL_LONG)   ? CNT_W'(STR_LONG) :
                             (str_sel == phy_timer_pkg::SEL_MEDIUM) ? CNT_W'(STR_MEDIUM) :
                                                                      CNT_W'(STR_NORMAL);
  wire [2:0] mode [2];
  logic [1:0] lit, led;
  assign mode[0] = ledcfg_q[phy_timer_pkg::MODE_A_LSB +: 3];
  assign mode[1] = ledcfg_q[phy_timer_pkg::MODE_B_LSB +: 3];

  for (genvar i = 0; i < 2; i++) begin : g_led
    event_stretch #(.CNT_W(CNT_W)) u_str (
      .clk_in        (clk_in),
      .rst_b_in      (rst_b_in),
      .ce_in         (ce_in),
      .pulse_in      (pick_event(mode[i], events_in) & en_q),
      .stretch_en_in (str_en),
      .len_in        (str_len),
      .lit_out       (lit[i])
    );
    assign led[i] = ~en_q ? 1'b0 :
                    (mode[i] == phy_timer_pkg::MODE_LINK)  ? events_in.link_up :
                    (mode[i] == phy_timer_pkg::MODE_ON)    ? 1'b1 :
                    (mode[i] == phy_timer_pkg::MODE_OFF)   ? 1'b0 :
                    (mode[i] == phy_timer_pkg::MODE_BLINK) ? events_in.link_up ^ lit[i] :
                                                             lit[i];
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ledcfg_q    <= phy_timer_pkg::LEDCFG_RST;
      dir_q       <= phy_timer_pkg::DIR_RST;
      port_data_q <= phy_timer_pkg::PORT_RST;
      fuse_q      <= 1'b0;
      pin_q       <= '0;
      oe_q        <= '0;
    end else if (ce_in) begin
      if (wr_led) ledcfg_q <= led_new[phy_timer_pkg::LEDCFG_W-1:0];
      if (wr_dir) dir_q <= dir_new[1:0];
      if (wr_port) port_data_q <= port_new[1:0];
      fuse_q <= indicator_fuse_bit_in;
      pin_q  <= fuse_q ? led : port_data_q;
      oe_q   <= ~dir_q;
    end
  end

  assign port_a_bit0_out    = pin_q[0];
  assign port_a_bit1_out    = pin_q[1];
  assign port_a_bit0_oe_out = oe_q[0];
  assign port_a_bit1_oe_out = oe_q[1];

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);

  a_ready_drop: assert property (
    (ce_in && wr_ctrl && !ctrl_new[phy_timer_pkg::ENABLE_BIT]) |=> !phy_ready_flag_out)
    else $error("ready flag survived disable");
  a_warm_start: assert property (
    (ce_in && state_q == phy_timer_pkg::ST_OFF && en_d) |=> state_q == phy_timer_pkg::ST_WARM)
    else $error("enable did not start timer");
  a_ready_time: assert property (
    (ce_in && state_q == phy_timer_pkg::ST_WARM && cnt_q == UP_LAST && en_d)
      |=> phy_ready_flag_out)
    else $error("ready not set at expiry");
  a_ready_cause: assert property (
    $rose(phy_ready_flag_out) |-> $past(cnt_q) == UP_LAST && en_q)
    else $error("ready set before full count");
  a_count_restart: assert property (
    $rose(en_q) |-> cnt_q == '0 ##1 (!ce_in || !en_q || cnt_q <= 1))
    else $error("timer did not restart from zero");
  a_pin_gpio: assert property (
    (ce_in && !fuse_q) |=> pin_q == $past(port_data_q))
    else $error("port pins not driven from port data");
  a_mode_on: assert property (
    (ce_in && fuse_q && en_q && mode[0] == phy_timer_pkg::MODE_ON) |=> port_a_bit0_out)
    else $error("indicator a not lit in on mode");
  a_len_long: assert property (
    (ce_in && str_en && str_sel == phy_timer_pkg::SEL_LONG && g_led[1].u_str.load)
      |=> g_led[1].u_str.cnt_q == CNT_W'(STR_LONG - 1))
    else $error("long stretch select misbehaved");
  a_bresp_after: assert property (
    (ce_in && wr_fire) |=> bvalid_q && !awready_q && !wready_q)
    else $error("write response missing");

  c_ready: cover property ($rose(phy_ready_flag_out));
  c_disable: cover property (phy_ready_flag_out ##1 !phy_ready_flag_out);
  c_write_split: cover property (aw_take && !w_take ##[1:4] w_take);
  c_read: cover property (ar_take ##1 rvalid_q);

endmodule

/* phy_timer_pkg.sv */
// constants, types and carriers for the phy ready timer and indicator block
package phy_timer_pkg;

  // ****************************************************************
  // clock and timing
  // ****************************************************************
  localparam int unsigned CLK_HZ         = 25_000_000;
  localparam int unsigned STARTUP_US     = 1000;
  localparam int unsigned STARTUP_CYCLES = CLK_HZ / 1_000_000 * STARTUP_US;
  localparam int unsigned STR_NORMAL_MS  = 40;
  localparam int unsigned STR_MEDIUM_MS  = 70;
  localparam int unsigned STR_LONG_MS    = 140;
  localparam int unsigned STR_NORMAL_CYC = CLK_HZ / 1000 * STR_NORMAL_MS;
  localparam int unsigned STR_MEDIUM_CYC = CLK_HZ / 1000 * STR_MEDIUM_MS;
  localparam int unsigned STR_LONG_CYC   = CLK_HZ / 1000 * STR_LONG_MS;
  localparam int unsigned STR_CNT_W      = 22;

  // ****************************************************************
  // register map
  // ****************************************************************
  localparam int unsigned ADDR_W       = 8;
  localparam logic [7:0]  CTRL_OFS     = 8'h00;
  localparam logic [7:0]  STATUS_OFS   = 8'h04;
  localparam logic [7:0]  LEDCFG_OFS   = 8'h08;
  localparam logic [7:0]  DIR_OFS      = 8'h0c;
  localparam logic [7:0]  PORT_OFS     = 8'h10;
  localparam int unsigned ENABLE_BIT   = 5;
  localparam int unsigned READY_BIT    = 0;
  localparam int unsigned STR_EN_BIT   = 1;
  localparam int unsigned STR_SEL_LSB  = 2;
  localparam int unsigned MODE_B_LSB   = 4;
  localparam int unsigned MODE_A_LSB   = 8;
  localparam int unsigned LEDCFG_W     = 11;
  localparam logic [10:0] LEDCFG_RST   = 11'h042;
  localparam logic [1:0]  DIR_RST      = 2'h3;
  localparam logic [1:0]  PORT_RST     = 2'h0;
  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;
  localparam logic [1:0]  SEL_MEDIUM   = 2'h1;
  localparam logic [1:0]  SEL_LONG     = 2'h2;

  // ****************************************************************
  // types
  // ****************************************************************
  typedef enum logic [2:0] {
    MODE_LINK  = 3'h0,
    MODE_TX    = 3'h1,
    MODE_RX    = 3'h2,
    MODE_COL   = 3'h3,
    MODE_TXRX  = 3'h4,
    MODE_ON    = 3'h5,
    MODE_OFF   = 3'h6,
    MODE_BLINK = 3'h7
  } led_mode_t;

  typedef enum logic [2:0] {
    ST_OFF   = 3'b001,
    ST_WARM  = 3'b010,
    ST_READY = 3'b100
  } up_state_t;

  typedef struct packed {
    logic              awvalid;
    logic [ADDR_W-1:0] awaddr;
    logic              wvalid;
    logic [31:0]       wdata;
    logic [3:0]        wstrb;
    logic              bready;
    logic              arvalid;
    logic [ADDR_W-1:0] araddr;
    logic              rready;
  } axil_m2s_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } axil_s2m_t;

  typedef struct packed {
    logic link_up;
    logic rx_act;
    logic tx_act;
    logic collision;
  } net_events_t;

endpackage

/* event_stretch.sv */
// pulse stretcher that keeps an indicator lit for a chosen length
`timescale 1ns/1ps
module event_stretch #(
  parameter int unsigned CNT_W = 22
) (
  input  wire logic             clk_in,
  input  wire logic             rst_b_in,
  input  wire logic             ce_in,
  input  wire logic             pulse_in,
  input  wire logic             stretch_en_in,
  input  wire logic [CNT_W-1:0] len_in,
  output logic                  lit_out
);

  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  logic             lit_q;
  logic             lit_d;
  wire              load = pulse_in & stretch_en_in;
  wire              busy = (cnt_q != '0);

  assign cnt_d = load ? len_in - 1'b1 : (busy ? cnt_q - 1'b1 : '0);
  assign lit_d = stretch_en_in ? (load | busy) : pulse_in;

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      cnt_q <= '0;
      lit_q <= 1'b0;
    end else if (ce_in) begin
      cnt_q <= cnt_d;
      lit_q <= lit_d;
    end
  end

  assign lit_out = lit_q;

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);

  a_stretch_hold: assert property (
    (ce_in && load && len_in > 2) |=> lit_q ##1 lit_q)
    else $error("stretched indicator dropped early");
  a_stretch_len: assert property (
    (ce_in && load) |=> cnt_q == $past(len_in) - 1'b1)
    else $error("stretch counter loaded with wrong length");
  c_stretch: cover property (ce_in && load ##1 busy);

endmodule

/* led_model.sv */
// external indicator led that measures how long it stays lit
`timescale 1ns/1ps
module led_model (
  input  wire logic   clk_in,
  input  wire logic   pin_in,
  input  wire logic   oe_in,
  output logic        level_out,
  output int unsigned last_len_out
);
  int unsigned run_q;
  // lit only while driven
  // led to ground pulls an undriven pin low
  assign level_out = oe_in ? pin_in : 1'b0;
  // two-state counters start at zero, so no separate initial driver
  always @(posedge clk_in) begin
    if (level_out) begin
      run_q <= run_q + 1;
    end else begin
      if (run_q != 0) last_len_out <= run_q;
      run_q <= 0;
    end
  end
endmodule

/* phy_ready_timer_led_stretch_tb_top.sv */
// testbench for the start-up timer and indicator block
`timescale 1ns/1ps
module phy_ready_timer_led_stretch_tb_top;
  // short counts keep the run brief
  localparam int unsigned SU = 20;
  localparam int unsigned LN [5] = '{5, 9, 17, 5, 1};
  logic                       clk_in, rst_b_in, ce_in, fuse, rdy, rdy_d, en;
  logic                       p0, p0_oe, p1, p1_oe, lv0, lv1;
  phy_timer_pkg::axil_m2s_t   m;
  phy_timer_pkg::axil_s2m_t   s;
  phy_timer_pkg::net_events_t ev;
  int unsigned                len0, len1, cyc, t_take, t_rise, t0, failures, checks;
  logic [31:0]                rd;
  logic [1:0]                 rsp;

  phy_ready_timer_led_stretch #(.STARTUP_CYCLES(SU), .STR_NORMAL(5), .STR_MEDIUM(9),
    .STR_LONG(17), .CNT_W(22)) u_dut (.clk_in(clk_in), .rst_b_in(rst_b_in), .ce_in(ce_in),
    .axil_in(m), .axil_out(s), .events_in(ev), .indicator_fuse_bit_in(fuse),
    .port_a_pins_in({lv1, lv0}), .port_a_bit0_out(p0), .port_a_bit0_oe_out(p0_oe),
    .port_a_bit1_out(p1), .port_a_bit1_oe_out(p1_oe), .net_unit_enable_out(en),
    .phy_ready_flag_out(rdy));
  led_model u_led_a (.clk_in(clk_in), .pin_in(p0), .oe_in(p0_oe), .level_out(lv0),
    .last_len_out(len0));
  led_model u_led_b (.clk_in(clk_in), .pin_in(p1), .oe_in(p1_oe), .level_out(lv1),
    .last_len_out(len1));

  // ****************************************************************
  // shared tasks
  // ****************************************************************
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    rdy_d <= rdy;
    if (rdy && !rdy_d) t_rise <= cyc;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    m.awaddr <= a;
    m.wdata <= d;
    m.wstrb <= 4'hf;
    m.awvalid <= 1'b1;
    m.wvalid <= 1'b1;
    m.bready <= 1'b1;
    // no local timeout; only the watchdog ends a stuck wait
    do begin
      @(posedge clk_in);
      if (m.awvalid && s.awready) m.awvalid <= 1'b0;
      if (m.wvalid && s.wready) m.wvalid <= 1'b0;
      if ((m.awvalid && s.awready) || (m.wvalid && s.wready)) t_take = cyc;
    end while (!(s.bvalid && m.bready));
    rsp = s.bresp;
    m.bready <= 1'b0;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
    @(posedge clk_in);
    m.araddr <= a;
    m.arvalid <= 1'b1;
    m.rready <= 1'b1;
    do begin
      @(posedge clk_in);
      if (m.arvalid && s.arready) m.arvalid <= 1'b0;
    end while (!(s.rvalid && m.rready));
    rd = s.rdata;
    rsp = s.rresp;
    m.rready <= 1'b0;
    chk(rd, exp);
    chk({30'h0, rsp}, {30'h0, er});
  endtask
  task automatic wait_ready;
    while (rdy !== 1'b1) begin
      @(posedge clk_in);
    end
    @(posedge clk_in);
  endtask

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_regs;
    rdchk(phy_timer_pkg::LEDCFG_OFS, 32'h042, phy_timer_pkg::RESP_OKAY);
    rdchk(phy_timer_pkg::DIR_OFS, 32'h3, phy_timer_pkg::RESP_OKAY);
    rdchk(phy_timer_pkg::CTRL_OFS, 32'h0, phy_timer_pkg::RESP_OKAY);
    rdchk(8'h14, 32'h0, phy_timer_pkg::RESP_SLVERR);
    wr(8'h18, 32'hffffffff);
    chk({30'h0, rsp}, {30'h0, phy_timer_pkg::RESP_SLVERR});
  endtask
  task automatic t_startup;
    wr(phy_timer_pkg::CTRL_OFS, 32'h20);
    t0 = t_take;
    chk(en, 1'b1);
    repeat (4) @(posedge clk_in);
    rdchk(phy_timer_pkg::STATUS_OFS, 32'h0, phy_timer_pkg::RESP_OKAY);
    wr(phy_timer_pkg::CTRL_OFS, 32'h20);
    wait_ready;
    // ready lands su edges after the enabling write edge; t_rise records it one edge later
    chk(t_rise - t0, SU + 1);
    rdchk(phy_timer_pkg::STATUS_OFS, 32'h1, phy_timer_pkg::RESP_OKAY);
    wr(phy_timer_pkg::CTRL_OFS, 32'h0);
    chk(rdy, 1'b0);
    chk(en, 1'b0);
    wr(phy_timer_pkg::CTRL_OFS, 32'h20);
    repeat (8) @(posedge clk_in);
    wr(phy_timer_pkg::CTRL_OFS, 32'h0);
    chk(rdy, 1'b0);
    wr(phy_timer_pkg::CTRL_OFS, 32'h20);
    t0 = t_take;
    // five frozen edges must not count toward the start-up time
    @(posedge clk_in);
    ce_in <= 1'b0;
    repeat (5) @(posedge clk_in);
    ce_in <= 1'b1;
    wait_ready;
    chk(t_rise - t0, SU + 6);
  endtask
  task automatic t_leds;
    logic [31:0] cfg;
    logic [2:0]  md [6];
    md = '{3'h0, 3'h3, 3'h5, 3'h6, 3'h7, 3'h6};
    @(posedge clk_in);
    fuse <= 1'b1;
    wr(phy_timer_pkg::DIR_OFS, 32'h0);
    @(posedge clk_in);
    chk({30'h0, p1_oe, p0_oe}, 32'h3);
    for (int i = 0; i < 5; i++) begin
      cfg = {21'h0, 3'h1, 1'b0, 3'h2, 2'(i % 4), (i < 4), 1'b0};
      wr(phy_timer_pkg::LEDCFG_OFS, cfg);
      ev.tx_act <= 1'b1;
      ev.rx_act <= 1'b1;
      @(posedge clk_in);
      ev.tx_act <= 1'b0;
      ev.rx_act <= 1'b0;
      repeat (25) @(posedge clk_in);
      chk(len0, LN[i]);
      chk(len1, LN[i]);
    end
    // a on collision, b on tx or rx; a reload from tx would show as 6
    wr(phy_timer_pkg::LEDCFG_OFS, 32'h342);
    ev.collision <= 1'b1;
    @(posedge clk_in);
    ev.collision <= 1'b0;
    ev.tx_act    <= 1'b1;
    @(posedge clk_in);
    ev.tx_act <= 1'b0;
    repeat (25) @(posedge clk_in);
    chk(len0, LN[0]);
    chk(len1, LN[0]);
    ev.link_up <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      wr(phy_timer_pkg::LEDCFG_OFS, {21'h0, md[i], 8'h0});
      repeat (4) @(posedge clk_in);
      chk(p0, (i % 2 == 0));
    end
    rdchk(phy_timer_pkg::PORT_OFS, 32'h2, phy_timer_pkg::RESP_OKAY);
    fuse <= 1'b0;
    wr(phy_timer_pkg::PORT_OFS, 32'h1);
    repeat (4) @(posedge clk_in);
    chk({p1, p0}, 2'h1);
  endtask

  task automatic print_verdict;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // ****************************************************************
  // clock, reset, sequence
  // ****************************************************************
  // one 25 mhz clock; never stopped while enabled
  initial begin
    clk_in = 1'b0;
    forever #20 clk_in = ~clk_in;
  end
  initial begin
    #(40 * 6000);
    failures++;
    print_verdict;
  end
  initial begin
    rst_b_in = 1'b0;
    ce_in = 1'b1;
    fuse = 1'b0;
    m = '0;
    ev = '0;
    failures = 0;
    checks = 0;
    repeat (6) @(posedge clk_in);
    rst_b_in <= 1'b1;
    t_regs;
    t_startup;
    t_leds;
    print_verdict;
  end
endmodule
